// File: host_port_pkg.sv
/*
 * Package for the parallel host port: bus schemes, the access record handed to
 * the register side, and the constants of the port.
 * Assumes a single synchronous clock domain; pins are already synchronous.
 */
package host_port_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int SEP_ADDR_W = 6;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
    localparam logic [1:0] SCHEME_RESET = 2'h0;

    typedef enum logic [1:0] {
        SCHEME_DIR_STROBE = 2'h0,
        SCHEME_SEPARATE = 2'h1,
        SCHEME_MUXED = 2'h2
    } scheme_type;

    // pin group as seen at the device boundary
    typedef struct packed {
        logic chipSelect_n;
        logic readDir;
        logic writeStrobe_n;
        logic accessStrobe_n;
        logic readStrobe_n;
        logic addrLatch;
        logic [SEP_ADDR_W-1:0] sepAddr;
        logic [DATA_W-1:0] busIn;
    } pins_type;

    // one completed access towards the register side
    typedef struct packed {
        logic isWrite;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } access_type;

endpackage

// File: host_port_edge.sv
/*
 * Rising and falling edge detector for one synchronous pin level.
 * Assumes the level is already synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module host_port_edge (
    input wire logic clk,
    input wire logic reset,
    input wire logic level,
    output logic rise,
    output logic fall
);

    logic level_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            // idle level of every watched signal is low, so no false edge after reset
            level_r <= 1'b0;
        end else begin
            level_r <= level;
        end
    end

    assign rise = level & ~level_r;
    assign fall = ~level & level_r;

endmodule

`default_nettype wire

// File: parallel_mcu_host_port.sv
/*
 * Eight-bit parallel host port: decodes the three strobe schemes, latches the
 * address, hands each finished write as a one-cycle pulse to the register side,
 * drives read data and the shared open-drain interrupt line.
 * Assumes all pins are synchronous to clk and strobes last at least two cycles.
 */
// Functional notes
// - host reads and programs the device over one 8-bit data path.
// - eight address bits are decoded on chip.
// - multiplexed bus carries address first, then data.
// - non-multiplexed bus carries data only.
// - separate address lines from bit 0 upward select the register.
// - nothing happens unless active-low chip select is low; the muxed ALE address latch ignores it.
// - direction high means read, low means write.
// - rising data strobe edge ends the access.
// - write strobe writes data into the addressed register.
// - read strobe drives addressed register contents onto the bus.
// - address latch enable high marks a valid address on the bus.
// - interrupt output active while an interrupt is pending.
// - interrupt line is open drain, only ever pulled low.
// - three selectable schemes: direction+strobe, separate, multiplexed.
`timescale 1ns/1ps
`default_nettype none

module parallel_mcu_host_port (
    input wire logic clk,
    input wire logic reset,
    input wire host_port_pkg::scheme_type scheme,
    input wire host_port_pkg::pins_type pins,
    output logic [host_port_pkg::DATA_W-1:0] busOut,
    output logic busOutEnable,
    output logic interruptOut,
    output logic interruptOutEnable,
    input wire logic irqPending,
    output logic [host_port_pkg::ADDR_W-1:0] readAddr,
    input wire logic [host_port_pkg::DATA_W-1:0] readData,
    output logic readStart,
    output host_port_pkg::access_type writeAccess,
    output logic writeValid
);

    typedef enum logic [1:0] {
        IDLE,
        READING,
        WRITING
    } phase_type;

    phase_type phase_r;
    host_port_pkg::scheme_type scheme_r;
    logic [host_port_pkg::ADDR_W-1:0] muxAddr_r;
    logic [host_port_pkg::DATA_W-1:0] busOut_r;
    logic [host_port_pkg::DATA_W-1:0] wrData_r;
    logic busOutEnable_r;
    logic selected;
    logic readActive;
    logic writeActive;
    logic strobeActive;
    logic strobeRise;
    logic strobeFall;
    logic aleRise;
    logic aleFall;
    logic [host_port_pkg::ADDR_W-1:0] curAddr;

    // strobe decode only counts under chip select; the muxed address latch samples the bus without it
    function automatic logic sel_ok(input logic csn);
        return ~csn;
    endfunction

    assign selected = sel_ok(pins.chipSelect_n);

    // scheme only changes between accesses so a live strobe is never reinterpreted
    always_ff @(posedge clk) begin
        if (reset) begin
            scheme_r <= host_port_pkg::scheme_type'(host_port_pkg::SCHEME_RESET);
        end else if (phase_r == IDLE) begin
            scheme_r <= scheme;
        end
    end

    // strobe decode per scheme
    always_comb begin
        readActive = 1'b0;
        writeActive = 1'b0;
        case (scheme_r)
            host_port_pkg::SCHEME_DIR_STROBE: begin
                readActive = selected & ~pins.accessStrobe_n & pins.readDir;
                writeActive = selected & ~pins.accessStrobe_n & ~pins.readDir;
            end
            default: begin
                readActive = selected & ~pins.readStrobe_n;
                writeActive = selected & ~pins.writeStrobe_n;
            end
        endcase
    end

    assign strobeActive = readActive | writeActive;

    host_port_edge strobeEdge (
        .clk(clk),
        .reset(reset),
        .level(strobeActive),
        .rise(strobeFall),
        .fall(strobeRise)
    );

    host_port_edge aleEdge (
        .clk(clk),
        .reset(reset),
        .level(pins.addrLatch),
        .rise(aleRise),
        .fall(aleFall)
    );

    // address is held past the latch strobe for the data phase
    always_ff @(posedge clk) begin
        if (reset) begin
            muxAddr_r <= host_port_pkg::ADDR_RESET;
        end else if (scheme_r == host_port_pkg::SCHEME_MUXED && aleFall) begin
            muxAddr_r <= pins.busIn;
        end
    end

    // separate lines are zero-extended to the full on-chip address
    always_comb begin
        if (scheme_r == host_port_pkg::SCHEME_MUXED) begin
            curAddr = muxAddr_r;
        end else begin
            curAddr = {{(host_port_pkg::ADDR_W - host_port_pkg::SEP_ADDR_W){1'b0}},
                       pins.sepAddr};
        end
    end

    assign readAddr = curAddr;
    assign readStart = strobeFall & readActive;

    // phase; strobe release ends the access in every scheme
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_r <= IDLE;
        end else begin
            case (phase_r)
                IDLE: begin
                    if (readActive) begin
                        phase_r <= READING;
                    end else if (writeActive) begin
                        phase_r <= WRITING;
                    end
                end
                READING: begin
                    if (!readActive) begin
                        phase_r <= IDLE;
                    end
                end
                default: begin
                    if (!writeActive) begin
                        phase_r <= IDLE;
                    end
                end
            endcase
        end
    end

    // write data is captured while the strobe is low, committed on release
    always_ff @(posedge clk) begin
        if (reset) begin
            wrData_r <= host_port_pkg::DATA_RESET;
        end else if (writeActive) begin
            wrData_r <= pins.busIn;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            writeValid <= 1'b0;
            writeAccess <= '0;
        end else begin
            writeValid <= (phase_r == WRITING) && strobeRise;
            if ((phase_r == WRITING) && strobeRise) begin
                writeAccess.isWrite <= 1'b1;
                writeAccess.addr <= curAddr;
                writeAccess.data <= wrData_r;
            end
        end
    end

    // read data follows the register side while the read is held
    always_ff @(posedge clk) begin
        if (reset) begin
            busOut_r <= host_port_pkg::DATA_RESET;
            busOutEnable_r <= 1'b0;
        end else begin
            busOutEnable_r <= readActive;
            if (readActive) begin
                busOut_r <= readData;
            end
        end
    end

    // gate with the live decode so drivers drop as soon as the strobe ends
    assign busOut = busOut_r;
    assign busOutEnable = busOutEnable_r & readActive;

    // open drain: value is always low, only the enable moves
    assign interruptOut = 1'b0;
    assign interruptOutEnable = irqPending;

    logic unusedAle;
    assign unusedAle = aleRise;

endmodule

`default_nettype wire

// File: host_port_chk.sv
/*
 * Concurrent checks on the host port's pins and register-side signals.
 * Assumes one clock domain and a bench that drives pins on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module host_port_chk (
    input wire logic clk,
    input wire logic reset,
    input wire host_port_pkg::scheme_type scheme,
    input wire host_port_pkg::pins_type pins,
    input wire logic [7:0] busOut,
    input wire logic busOutEnable,
    input wire logic interruptOut,
    input wire logic interruptOutEnable,
    input wire logic irqPending,
    input wire logic [7:0] readAddr,
    input wire logic [7:0] readData,
    input wire logic readStart,
    input wire host_port_pkg::access_type writeAccess,
    input wire logic writeValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic sel = !pins.chipSelect_n;
    wr_pulse_a: assert property (writeValid |=> !writeValid)
        else $error("write pulse longer than one cycle");
    cs_gate_a: assert property (readStart || busOutEnable |-> sel)
        else $error("activity without chip select");
    irq_od_a: assert property (!interruptOut)
        else $error("interrupt line driven high");
    irq_pend_a: assert property (interruptOutEnable == irqPending)
        else $error("interrupt pull does not follow pending");
    read_data_a: assert property (busOutEnable |-> busOut == $past(readData))
        else $error("read data not on bus");
    oe_rise_a: assert property (readStart |=> busOutEnable)
        else $error("drivers not enabled after read start");
    sep_addr_a: assert property (readStart && scheme != 2'h2
        |-> readAddr == {2'h0, pins.sepAddr}) else $error("separate address wrong");
    wr_end_a: assert property ($rose(pins.writeStrobe_n) && sel && scheme == 2'h1
        |=> writeValid) else $error("write strobe end gave no write");
    ds_end_a: assert property ($rose(pins.accessStrobe_n) && sel && scheme == 2'h0
        && !pins.readDir |=> writeValid ##1 !writeValid) else $error("strobe end gave no write");
    dir_read_a: assert property ($fell(pins.accessStrobe_n) && sel
        && scheme == 2'h0 && pins.readDir |-> readStart) else $error("direction read missed");
    mux_addr_a: assert property ($fell(pins.addrLatch) && sel && scheme == 2'h2
        |=> readAddr == $past(pins.busIn)) else $error("latched address wrong");
endmodule
bind parallel_mcu_host_port host_port_chk u_chk (.clk(clk), .reset(reset), .scheme(scheme),
    .pins(pins), .busOut(busOut), .busOutEnable(busOutEnable), .interruptOut(interruptOut),
    .interruptOutEnable(interruptOutEnable), .irqPending(irqPending), .readAddr(readAddr),
    .readData(readData), .readStart(readStart), .writeAccess(writeAccess),
    .writeValid(writeValid));
`default_nettype wire

// File: host_mcu_model.sv
/*
 * Host microcontroller model: runs one bus access per call, pins change on falling edges.
 * Assumes the bench resolves the shared bus from the device's output enable alone; the host has no enable.
 */
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
    input wire logic clk,
    output host_port_pkg::pins_type pins,
    output host_port_pkg::scheme_type scheme
);
    initial begin
        pins = '1;
        pins.addrLatch = 1'b0;
        scheme = host_port_pkg::SCHEME_DIR_STROBE;
    end
    task automatic access(input host_port_pkg::scheme_type s, input logic w,
        input logic [7:0] a, input logic [7:0] d, input logic sel, input int hold);
        logic mux;
        mux = (s == host_port_pkg::SCHEME_MUXED);
        @(negedge clk);
        scheme = s;
        // scheme is only taken while idle, so it leads the access by a cycle
        @(negedge clk);
        pins.chipSelect_n = !sel;
        // muxed ignores these lines, so feed it a wrong address
        pins.sepAddr = mux ? ~a[5:0] : a[5:0];
        if (mux) begin
            pins.busIn = a;
            pins.addrLatch = 1'b1;
            @(negedge clk);
            pins.addrLatch = 1'b0;
            @(negedge clk);
        end
        pins.busIn = w ? d : ~a;
        pins.readDir = !w;
        pins.accessStrobe_n = (s != host_port_pkg::SCHEME_DIR_STROBE);
        pins.writeStrobe_n = !(w && s != host_port_pkg::SCHEME_DIR_STROBE);
        pins.readStrobe_n = !(!w && s != host_port_pkg::SCHEME_DIR_STROBE);
        repeat (hold) @(negedge clk);
        pins.accessStrobe_n = 1'b1;
        pins.writeStrobe_n = 1'b1;
        pins.readStrobe_n = 1'b1;
        @(negedge clk);
        pins.chipSelect_n = 1'b1;
        pins.busIn = ~pins.busIn;
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
/*
 * Self-checking bench: random accesses in all three schemes, refused ones included.
 * Assumes the host model and the checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic irqPending = 1'b0;
    logic oePrev = 1'b0;
    logic [31:0] rnd = 32'hdd3b_1522;
    int fails = 0;
    int testsRun = 0;
    host_port_pkg::pins_type hostPins, dutPins;
    host_port_pkg::scheme_type scheme, s;
    host_port_pkg::access_type writeAccess, expAcc;
    host_port_pkg::access_type expQ[$];
    logic [7:0] busOut, readAddr, a, d;
    logic busOutEnable, interruptOut, interruptOutEnable, readStart, writeValid, w, sel;
    always #20 clk = ~clk;
    // shared bus: the device wins while its drivers are on
    always_comb begin
        dutPins = hostPins;
        if (busOutEnable) begin
            dutPins.busIn = busOut;
        end
    end
    host_mcu_model u_host (.clk(clk), .pins(hostPins), .scheme(scheme));
    parallel_mcu_host_port u_dut (.clk(clk), .reset(reset), .scheme(scheme), .pins(dutPins),
        .busOut(busOut), .busOutEnable(busOutEnable), .interruptOut(interruptOut),
        .interruptOutEnable(interruptOutEnable), .irqPending(irqPending),
        .readAddr(readAddr), .readData(readAddr ^ 8'ha5), .readStart(readStart),
        .writeAccess(writeAccess), .writeValid(writeValid));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic check(input string what, input logic [16:0] e, input logic [16:0] g);
        testsRun++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", what, e, g);
            fails++;
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        if (!reset && (writeValid || (busOutEnable && !oePrev))) begin
            expAcc = (expQ.size() > 0) ? expQ.pop_front() : 'x;
            check("access", expAcc, writeValid ? writeAccess : {1'b0, readAddr, busOut});
        end
        oePrev <= busOutEnable;
    end
    initial begin
        #80000;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 30; i++) begin
            rnd = xs(rnd);
            s = host_port_pkg::scheme_type'(i % 3);
            w = rnd[0];
            a = (i % 3 == 2) ? rnd[15:8] : {2'h0, rnd[13:8]};
            d = rnd[23:16];
            sel = (i % 7 != 3);
            irqPending = rnd[24];
            if (sel) begin
                expQ.push_back({w, a, w ? d : a ^ 8'ha5});
            end
            u_host.access(s, w, a, d, sel, 2 + int'(rnd[27:25]) % 3);
            check("irq", {16'h0, !irqPending}, {16'h0, !interruptOutEnable});
        end
        repeat (4) @(negedge clk);
        check("left", 17'h0_0000, 17'(expQ.size()));
        give_verdict();
    end
endmodule
`default_nettype wire
